// ---- common/dsbrc_pkg.sv ----
// Purpose: shared constants for the dual supply brown-out reset control
// Assumes: 32-bit AXI4-Lite register bus, 8-bit registers in the low byte
// Notes: data memory map figures describe the core's banked data space
`default_nettype none
package dsbrc_pkg;
	localparam int AXI_ADDR_W = 8;
	localparam int REG_W = 8;
	localparam int MEM_ADDR_W = 13;
	// register byte offsets
	localparam logic [7:0] OFF_BROWNOUT_CTRL = 8'h00;
	localparam logic [7:0] OFF_CAUSE_FLAGS = 8'h04;
	localparam logic [7:0] OFF_CAUSE_EXTRA = 8'h08;
	localparam logic [7:0] OFF_CORE_STATUS = 8'h0c;
	localparam logic [7:0] OFF_WDOG_CTRL = 8'h10;
	localparam logic [7:0] OFF_SCRATCH_0 = 8'h14;
	localparam logic [7:0] OFF_SCRATCH_3 = 8'h20;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h24;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h28;
	// implemented-bit masks, everything else reads zero
	localparam logic [7:0] MASK_BROWNOUT_CTRL = 8'h81;
	localparam logic [7:0] MASK_CAUSE_FLAGS = 8'hff;
	localparam logic [7:0] MASK_CAUSE_EXTRA = 8'h03;
	localparam logic [7:0] MASK_CORE_STATUS = 8'h1f;
	localparam logic [7:0] MASK_WDOG_CTRL = 8'h3f;
	localparam logic [7:0] MASK_IRQ = 8'h03;
	// field positions
	localparam int BIT_SOFT_BOR_EN = 7;
	localparam int BIT_BOR_READY = 0;
	localparam int BIT_MAIN_FLAG = 0;
	localparam int BIT_BAT_FLAG = 0;
	localparam int BIT_IRQ_MAIN = 0;
	localparam int BIT_IRQ_BAT = 1;
	// reset values
	localparam logic [7:0] RST_BROWNOUT_CTRL = 8'h80;
	localparam logic [7:0] RST_CAUSE_FLAGS = 8'h00;
	localparam logic [7:0] RST_CAUSE_EXTRA = 8'h00;
	localparam logic [7:0] RST_OTHER = 8'h00;
	// banked data space, banks 30..57
	localparam logic [12:0] UNIMP_LO = 13'h0f0c;
	localparam logic [12:0] UNIMP_HI = 13'h1c9f;
	localparam logic [6:0] BANK_CORE_END = 7'h0c;
	localparam logic [6:0] BANK_COMMON_LO = 7'h70;
	localparam logic [1:0] RESP_OKAY = 2'h0;
endpackage
`default_nettype wire

// ---- common/dsbrc_sup_if.sv ----
// Purpose: carries supply comparator inputs and domain decisions
// Assumes: one clock domain
// Notes: comparator inputs driven by the top; decisions driven by the supply decision module, read by the top
`default_nettype none
interface dsbrc_sup_if;
	logic mainOk;
	logic batOk;
	logic batHigher;
	logic calOnBattery;
	logic coreReset;
	logic calendarReset;
	logic mainEvt;
	logic batEvt;
	modport decide (input mainOk, batOk, batHigher,
		output calOnBattery, coreReset, calendarReset, mainEvt, batEvt);
	modport use_side (output mainOk, batOk, batHigher,
		input calOnBattery, coreReset, calendarReset, mainEvt, batEvt);
endinterface
`default_nettype wire

// ---- hdl/dsbrc_supply.sv ----
// Purpose: supply domain decision from the two brown-out comparators
// Assumes: comparator levels synchronous to clk
// Notes: all outputs registered, one cycle after the inputs
`default_nettype none
module dsbrc_supply (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	dsbrc_sup_if.decide sup
);
	logic calOnBattery_q;
	logic coreReset_q;
	logic calendarReset_q;
	logic mainLow_q;
	logic bothLow_q;
	logic mainEvt_q;
	logic batEvt_q;

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			calOnBattery_q <= 1'b0;
			coreReset_q <= 1'b1;
			calendarReset_q <= 1'b1;
		end else if (ce) begin
			// battery takes only the calendar and its oscillator
			calOnBattery_q <= sup.batOk & (~sup.mainOk | sup.batHigher);
			coreReset_q <= ~sup.mainOk;
			calendarReset_q <= ~sup.mainOk & ~sup.batOk;
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mainLow_q <= 1'b0;
			bothLow_q <= 1'b0;
			mainEvt_q <= 1'b0;
			batEvt_q <= 1'b0;
		end else if (ce) begin
			mainLow_q <= ~sup.mainOk;
			bothLow_q <= ~sup.mainOk & ~sup.batOk;
			mainEvt_q <= ~sup.mainOk & ~mainLow_q;
			batEvt_q <= ~sup.mainOk & ~sup.batOk & ~bothLow_q;
		end
	end

	assign sup.calOnBattery = calOnBattery_q;
	assign sup.coreReset = coreReset_q;
	assign sup.calendarReset = calendarReset_q;
	assign sup.mainEvt = mainEvt_q;
	assign sup.batEvt = batEvt_q;
endmodule
`default_nettype wire

// ---- hdl/dsbrc_top.sv ----
// Purpose: brown-out reset control for a main and a battery supply
// Assumes: comparator results, not analog levels; AXI4-Lite registers
// Notes: flags are cleared by hardware and restored by software
//
// Behaviour
// - both supplies good: all on main, calendar on battery if battery higher
// - main supply good: both brown-out flags keep their value
// - only battery good: calendar and oscillator run, everything else held
// - main below threshold clears main flag; battery flag kept if battery good
// - both below threshold: all held in reset, both flags cleared
// - unimplemented locations and register bits read as zero
`default_nettype none
module dsbrc_top #(
	parameter int MEM_ADDR_W = dsbrc_pkg::MEM_ADDR_W
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic mainAboveBor,
	input wire logic batAboveBor,
	input wire logic batAboveMain,
	input wire logic borReady,
	input wire logic memRdValid,
	input wire logic [MEM_ADDR_W-1:0] memRdAddr,
	input wire logic [7:0] memRdDataIn,
	output logic [7:0] memRdDataOut,
	output logic memRdDataValid,
	output logic calOnBattery,
	output logic coreReset,
	output logic calendarReset,
	output logic irq,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	if (MEM_ADDR_W != 13) begin : g_chk
		$error("dsbrc_top: data address must be 13 bits");
	end

	dsbrc_sup_if sup ();
	assign sup.mainOk = mainAboveBor;
	assign sup.batOk = batAboveBor;
	assign sup.batHigher = batAboveMain;

	dsbrc_supply u_supply (
		.clk(clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.sup(sup)
	);
	assign calOnBattery = sup.calOnBattery;
	assign coreReset = sup.coreReset;
	assign calendarReset = sup.calendarReset;

	////////////////////////////////////////////////////////////////////////
	// write channel: address and data latched independently
	logic [7:0] awAddr_q;
	logic awHeld_q;
	logic [7:0] wData_q;
	logic wStrb0_q;
	logic wHeld_q;
	logic bvalid_q;
	logic doWrite;

	assign s_axi_awready = ce & ~awHeld_q;
	assign s_axi_wready = ce & ~wHeld_q;
	assign doWrite = ce & awHeld_q & wHeld_q & ~bvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = dsbrc_pkg::RESP_OKAY;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			awAddr_q <= 8'h00;
			awHeld_q <= 1'b0;
			wData_q <= 8'h00;
			wStrb0_q <= 1'b0;
			wHeld_q <= 1'b0;
			bvalid_q <= 1'b0;
		end else if (ce) begin
			if (s_axi_awvalid & ~awHeld_q) begin
				awAddr_q <= {s_axi_awaddr[7:2], 2'b00};
				awHeld_q <= 1'b1;
			end
			if (s_axi_wvalid & ~wHeld_q) begin
				wData_q <= s_axi_wdata[7:0];
				wStrb0_q <= s_axi_wstrb[0];
				wHeld_q <= 1'b1;
			end
			if (doWrite) begin
				bvalid_q <= 1'b1;
				awHeld_q <= 1'b0;
				wHeld_q <= 1'b0;
			end else if (bvalid_q & s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	logic wrEn;
	assign wrEn = doWrite & wStrb0_q;

	////////////////////////////////////////////////////////////////////////
	// reset cause flags; hardware clear wins over a software restore
	logic [7:0] ctrl_q;
	logic [7:0] cause_q;
	logic [7:0] extra_q;
	logic wrCause;
	logic wrExtra;
	assign wrCause = wrEn & (awAddr_q == dsbrc_pkg::OFF_CAUSE_FLAGS);
	assign wrExtra = wrEn & (awAddr_q == dsbrc_pkg::OFF_CAUSE_EXTRA);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cause_q <= dsbrc_pkg::RST_CAUSE_FLAGS;
		end else if (ce) begin
			if (wrCause)
				cause_q <= wData_q;
			if (~mainAboveBor)
				cause_q[dsbrc_pkg::BIT_MAIN_FLAG] <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			extra_q <= dsbrc_pkg::RST_CAUSE_EXTRA;
		end else if (ce) begin
			if (wrExtra)
				extra_q <= wData_q & dsbrc_pkg::MASK_CAUSE_EXTRA;
			// battery flag only falls when both supplies are gone
			if (~mainAboveBor & ~batAboveBor)
				extra_q[dsbrc_pkg::BIT_BAT_FLAG] <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// plain storage registers
	logic [7:0] status_q;
	logic [7:0] wdog_q;
	logic [7:0] scratch_q [4];
	logic [1:0] irqSt_q;
	logic [1:0] irqMask_q;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrl_q <= dsbrc_pkg::RST_BROWNOUT_CTRL;
			status_q <= dsbrc_pkg::RST_OTHER;
			wdog_q <= dsbrc_pkg::RST_OTHER;
		end else if (wrEn) begin
			unique case (awAddr_q)
				dsbrc_pkg::OFF_BROWNOUT_CTRL: ctrl_q <= wData_q & 8'h80;
				dsbrc_pkg::OFF_CORE_STATUS: status_q <= wData_q & dsbrc_pkg::MASK_CORE_STATUS;
				dsbrc_pkg::OFF_WDOG_CTRL: wdog_q <= wData_q & dsbrc_pkg::MASK_WDOG_CTRL;
				default: ;
			endcase
		end
	end

	for (genvar i = 0; i < 4; i++) begin : g_scratch
		always_ff @(posedge clk) begin
			if (sys_rst)
				scratch_q[i] <= dsbrc_pkg::RST_OTHER;
			else if (wrEn && awAddr_q == dsbrc_pkg::OFF_SCRATCH_0 + 8'(4 * i))
				scratch_q[i] <= wData_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupts: event set wins over write-one-to-clear
	logic [1:0] irqClr;
	assign irqClr = (wrEn && awAddr_q == dsbrc_pkg::OFF_IRQ_STATUS) ? wData_q[1:0] : 2'b00;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irqSt_q <= 2'b00;
			irqMask_q <= 2'b00;
		end else if (ce) begin
			irqSt_q <= (irqSt_q & ~irqClr) | {sup.batEvt, sup.mainEvt};
			if (wrEn && awAddr_q == dsbrc_pkg::OFF_IRQ_MASK)
				irqMask_q <= wData_q[1:0];
		end
	end
	assign irq = |(irqSt_q & irqMask_q);

	////////////////////////////////////////////////////////////////////////
	// read channel
	logic [31:0] rdata_q;
	logic rvalid_q;
	logic [7:0] rdMux;
	logic [7:0] arAddr;
	assign arAddr = {s_axi_araddr[7:2], 2'b00};
	assign s_axi_arready = ce & ~rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = dsbrc_pkg::RESP_OKAY;

	always_comb begin
		rdMux = 8'h00;
		unique case (arAddr)
			dsbrc_pkg::OFF_BROWNOUT_CTRL: rdMux = {ctrl_q[7], 6'h00, borReady};
			dsbrc_pkg::OFF_CAUSE_FLAGS: rdMux = cause_q;
			dsbrc_pkg::OFF_CAUSE_EXTRA: rdMux = extra_q & dsbrc_pkg::MASK_CAUSE_EXTRA;
			dsbrc_pkg::OFF_CORE_STATUS: rdMux = status_q;
			dsbrc_pkg::OFF_WDOG_CTRL: rdMux = wdog_q;
			8'h14: rdMux = scratch_q[0];
			8'h18: rdMux = scratch_q[1];
			8'h1c: rdMux = scratch_q[2];
			dsbrc_pkg::OFF_SCRATCH_3: rdMux = scratch_q[3];
			dsbrc_pkg::OFF_IRQ_STATUS: rdMux = {6'h00, irqSt_q};
			dsbrc_pkg::OFF_IRQ_MASK: rdMux = {6'h00, irqMask_q};
			default: rdMux = 8'h00;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdata_q <= 32'h0000_0000;
			rvalid_q <= 1'b0;
		end else if (ce) begin
			if (s_axi_arvalid & ~rvalid_q) begin
				rdata_q <= {24'h000000, rdMux};
				rvalid_q <= 1'b1;
			end else if (rvalid_q & s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// data memory read filter; core regs and common ram stay visible
	logic unimpl;
	logic [7:0] memData_q;
	logic memValid_q;
	assign unimpl = (memRdAddr >= dsbrc_pkg::UNIMP_LO) && (memRdAddr <= dsbrc_pkg::UNIMP_HI)
		&& (memRdAddr[6:0] >= dsbrc_pkg::BANK_CORE_END)
		&& (memRdAddr[6:0] < dsbrc_pkg::BANK_COMMON_LO);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			memData_q <= 8'h00;
			memValid_q <= 1'b0;
		end else if (ce) begin
			memValid_q <= memRdValid;
			if (memRdValid)
				memData_q <= unimpl ? 8'h00 : memRdDataIn;
		end
	end
	assign memRdDataOut = memData_q;
	assign memRdDataValid = memValid_q;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	calOnMain_a: assert property (ce && mainAboveBor && batAboveBor && !batAboveMain
		|=> !calOnBattery && !coreReset)
		else $error("calendar not on main supply");
	batOnly_a: assert property (ce && !mainAboveBor && batAboveBor
		|=> calOnBattery && coreReset && !calendarReset)
		else $error("battery-only domain wrong");
	allHeld_a: assert property (ce && !mainAboveBor && !batAboveBor
		|=> coreReset && calendarReset && !extra_q[0] && !cause_q[0])
		else $error("both-low state wrong");
	mainKeep_a: assert property (ce && mainAboveBor && !wrCause && !wrExtra
		|=> $stable(cause_q[0]) && $stable(extra_q[0]))
		else $error("flags moved while main good");
	mainClear_a: assert property (ce && !mainAboveBor |=> !cause_q[0])
		else $error("main flag not cleared");
	batKeep_a: assert property (ce && batAboveBor && !wrExtra |=> $stable(extra_q[0]))
		else $error("battery flag moved");
	flagSticky_a: assert property (ce && !cause_q[0] && mainAboveBor && !wrCause
		|=> !cause_q[0])
		else $error("main flag rose without write");
	memZero_a: assert property (ce && memRdValid && unimpl
		|=> memRdDataValid && memRdDataOut == 8'h00)
		else $error("unimplemented data read nonzero");
	regZero_a: assert property (ce && s_axi_arvalid && s_axi_arready
		&& s_axi_araddr[7:2] > 6'h0a |=> s_axi_rvalid && s_axi_rdata == 32'h0)
		else $error("unmapped register read nonzero");
	irqLevel_a: assert property (ce && sup.mainEvt && irqMask_q[0] && !sys_rst
		|=> ##[0:1] irq)
		else $error("interrupt missing after main event");

	batOnly_c: cover property (ce && !mainAboveBor && batAboveBor ##1 calOnBattery);
	bothLow_c: cover property (ce && !mainAboveBor && !batAboveBor ##1 calendarReset);
	restore_c: cover property (!cause_q[0] ##[1:50] cause_q[0]);
	irq_c: cover property (irq);
endmodule
`default_nettype wire

// ---- bench/dsbrc_comparator_model.sv ----
// Purpose: behavioural model of the main and battery brown-out comparators
// Assumes: the bench commands each supply level, comparators settle within one edge
// Notes: outputs are levels that change only just after a rising edge
`default_nettype none
module dsbrc_comparator_model (
	input wire logic clk,
	input wire logic wantMain,
	input wire logic wantBat,
	input wire logic wantBatHigh,
	output logic mainAboveBor,
	output logic batAboveBor,
	output logic batAboveMain
);
	timeunit 1ns;
	timeprecision 1ps;
	// registered so that a supply change never lands in the sampling step
	always_ff @(posedge clk) begin
		mainAboveBor <= wantMain;
		batAboveBor <= wantBat;
		batAboveMain <= wantBatHigh;
	end
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// Purpose: self-checking bench for the dual supply brown-out reset control
// Assumes: registers over AXI4-Lite, comparators modelled in their own module
// Notes: every scenario is a task that drives and judges on its own
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, sys_rst, ce, wantMain, wantBat, wantBatHigh, borReady, irq;
	logic mainAboveBor, batAboveBor, batAboveMain, calOnBattery, coreReset, calendarReset;
	logic memRdValid, memRdDataValid;
	logic [12:0] memRdAddr;
	logic [7:0] memRdDataIn, memRdDataOut, s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int errors;
	int nTests;
	localparam logic [7:0] REG_OFF [9] = '{dsbrc_pkg::OFF_BROWNOUT_CTRL,
		dsbrc_pkg::OFF_CAUSE_FLAGS, dsbrc_pkg::OFF_CAUSE_EXTRA, dsbrc_pkg::OFF_CORE_STATUS,
		dsbrc_pkg::OFF_WDOG_CTRL, dsbrc_pkg::OFF_SCRATCH_0, 8'h18, 8'h1c, dsbrc_pkg::OFF_SCRATCH_3};
	localparam logic [7:0] REG_MASK [9] = '{dsbrc_pkg::MASK_BROWNOUT_CTRL,
		dsbrc_pkg::MASK_CAUSE_FLAGS, dsbrc_pkg::MASK_CAUSE_EXTRA, dsbrc_pkg::MASK_CORE_STATUS,
		dsbrc_pkg::MASK_WDOG_CTRL, 8'hff, 8'hff, 8'hff, 8'hff};

	dsbrc_comparator_model i_dsbrc_comparator_model (.clk, .wantMain, .wantBat, .wantBatHigh,
		.mainAboveBor, .batAboveBor, .batAboveMain);
	dsbrc_top i_dsbrc_top (.clk, .sys_rst, .ce, .mainAboveBor, .batAboveBor, .batAboveMain,
		.borReady, .memRdValid, .memRdAddr, .memRdDataIn, .memRdDataOut, .memRdDataValid,
		.calOnBattery, .coreReset, .calendarReset, .irq, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

	////////////////////////////////////////////////////////////////////////////////
	task automatic endOfTest();
		if (errors == 0 && nTests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		nTests++;
		if (got !== exp) begin
			$display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
			errors++;
		end
	endtask

	// a hung handshake ends the run here rather than at a global limit
	task automatic timedOut(input int n);
		if (n >= 40) begin
			errors++;
			endOfTest();
		end
	endtask

	task automatic axiWrite(input logic [7:0] addr, input logic [7:0] data);
		int n;
		@(posedge clk);
		s_axi_awaddr <= addr;
		s_axi_wdata <= {24'h000000, data};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
			n++;
		end while (s_axi_bvalid !== 1'b1 && n < 40);
		s_axi_bready <= 1'b0;
		timedOut(n);
		check({30'h0, s_axi_bresp}, {30'h0, dsbrc_pkg::RESP_OKAY});
	endtask

	// upper lanes are compared too, they must read zero
	task automatic readCheck(input logic [7:0] addr, input logic [7:0] exp);
		int n;
		@(posedge clk);
		s_axi_araddr <= addr;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
			n++;
		end while (s_axi_rvalid !== 1'b1 && n < 40);
		s_axi_rready <= 1'b0;
		timedOut(n);
		check(s_axi_rdata, {24'h000000, exp});
		check({30'h0, s_axi_rresp}, {30'h0, dsbrc_pkg::RESP_OKAY});
	endtask

	// exp is {calOnBattery, coreReset, calendarReset, irq}
	task automatic supplyCase(input logic m, input logic b, input logic h, input logic [3:0] exp);
		@(posedge clk);
		wantMain <= m;
		wantBat <= b;
		wantBatHigh <= h;
		repeat (4) @(posedge clk);
		#1;
		check({28'h0, calOnBattery, coreReset, calendarReset, irq}, {28'h0, exp});
	endtask

	task automatic memRead(input logic [12:0] addr, input logic [7:0] exp);
		@(posedge clk);
		memRdValid <= 1'b1;
		memRdAddr <= addr;
		memRdDataIn <= 8'ha5;
		@(posedge clk);
		memRdValid <= 1'b0;
		#1;
		check({23'h0, memRdDataValid, memRdDataOut}, {23'h0, 1'b1, exp});
		@(posedge clk);
		#1;
		check({31'h0, memRdDataValid}, 32'h0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic testRegisters();
		for (int i = 0; i < 9; i++) begin
			readCheck(REG_OFF[i], (i == 0) ? 8'h81 : 8'h00);
			axiWrite(REG_OFF[i], 8'hff);
			readCheck(REG_OFF[i], REG_MASK[i]);
		end
		readCheck(dsbrc_pkg::OFF_IRQ_STATUS, 8'h00);
		readCheck(dsbrc_pkg::OFF_IRQ_MASK, 8'h00);
		axiWrite(8'h2c, 8'hff);
		readCheck(8'h2c, 8'h00);
		readCheck(8'hfc, 8'h00);
		borReady <= 1'b0;
		axiWrite(dsbrc_pkg::OFF_BROWNOUT_CTRL, 8'h00);
		readCheck(dsbrc_pkg::OFF_BROWNOUT_CTRL, 8'h00);
		borReady <= 1'b1;
	endtask

	task automatic testSupply();
		axiWrite(dsbrc_pkg::OFF_IRQ_MASK, 8'h01);
		supplyCase(1'b1, 1'b0, 1'b0, 4'b0000);
		readCheck(dsbrc_pkg::OFF_CAUSE_FLAGS, 8'hff);
		readCheck(dsbrc_pkg::OFF_CAUSE_EXTRA, 8'h03);
		supplyCase(1'b1, 1'b1, 1'b1, 4'b1000);
		supplyCase(1'b1, 1'b1, 1'b0, 4'b0000);
		supplyCase(1'b0, 1'b1, 1'b0, 4'b1101);
		readCheck(dsbrc_pkg::OFF_CAUSE_FLAGS, 8'hfe);
		readCheck(dsbrc_pkg::OFF_CAUSE_EXTRA, 8'h03);
		readCheck(dsbrc_pkg::OFF_IRQ_STATUS, 8'h01);
		axiWrite(dsbrc_pkg::OFF_IRQ_STATUS, 8'h01);
		check({31'h0, irq}, 32'h0);
		supplyCase(1'b1, 1'b1, 1'b0, 4'b0000);
		readCheck(dsbrc_pkg::OFF_CAUSE_FLAGS, 8'hfe);
		axiWrite(dsbrc_pkg::OFF_CAUSE_FLAGS, 8'hff);
		readCheck(dsbrc_pkg::OFF_CAUSE_FLAGS, 8'hff);
		axiWrite(dsbrc_pkg::OFF_IRQ_MASK, 8'h00);
		supplyCase(1'b0, 1'b0, 1'b0, 4'b0110);
		readCheck(dsbrc_pkg::OFF_CAUSE_FLAGS, 8'hfe);
		readCheck(dsbrc_pkg::OFF_CAUSE_EXTRA, 8'h02);
		readCheck(dsbrc_pkg::OFF_IRQ_STATUS, 8'h03);
		axiWrite(dsbrc_pkg::OFF_IRQ_MASK, 8'h03);
		check({31'h0, irq}, 32'h1);
		axiWrite(dsbrc_pkg::OFF_IRQ_STATUS, 8'h03);
		check({31'h0, irq}, 32'h0);
		supplyCase(1'b1, 1'b1, 1'b0, 4'b0000);
	endtask

	task automatic testMemory();
		memRead(13'h0f0b, 8'ha5);
		memRead(13'h0f0c, 8'h00);
		memRead(13'h150c, 8'h00);
		memRead(13'h0f70, 8'ha5);
		memRead(13'h1c8b, 8'ha5);
		memRead(13'h1c9f, 8'h00);
		memRead(13'h1ca0, 8'ha5);
	endtask

	// a frozen block must ignore a supply loss until enable returns
	task automatic testFreeze();
		@(posedge clk);
		ce <= 1'b0;
		wantMain <= 1'b0;
		repeat (4) @(posedge clk);
		#1;
		check({27'h0, calOnBattery, coreReset, calendarReset, s_axi_awready, s_axi_arready},
			32'h0);
		@(posedge clk);
		ce <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
		check({28'h0, calOnBattery, coreReset, calendarReset, irq}, 32'hd);
		readCheck(dsbrc_pkg::OFF_IRQ_STATUS, 8'h01);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		errors = 0;
		nTests = 0;
		sys_rst = 1'b1;
		ce = 1'b1;
		wantMain = 1'b1;
		wantBat = 1'b1;
		wantBatHigh = 1'b0;
		borReady = 1'b1;
		memRdValid = 1'b0;
		memRdAddr = 13'h0000;
		memRdDataIn = 8'h00;
		s_axi_awaddr = 8'h00;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = 32'h00000000;
		s_axi_wstrb = 4'h1;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_araddr = 8'h00;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		testRegisters();
		testSupply();
		testMemory();
		testFreeze();
		endOfTest();
	end
endmodule
`default_nettype wire
